// File: rtl/wwsup_core.sv
// Windowed watchdog supervisor: power hold, window watchdog, safety gate
`timescale 1ns/1ps
`default_nettype none
`include "wwsup_cfg.svh"
// Notes on behaviour
// - After voltage becomes good, hold reset through the full power-on delay.
// - Voltage below threshold forces reset, overriding all watchdog timing.
// - Kick too early or too late produces a reset.
// - Safety gate stays inactive until three successful services.
// - Four service windows in a row without a kick select the fallback standby timing.
// - Shut window is 0.8 of watch period, starting at timer restart.
// - Service window is 0.4 of watch period, right after shut window.
// - Fault pulse lasts one fortieth of the watch period.
// - Power-on hold derives from the same clock, nominally 100 ms.
// - Watch period nominally 100 ms; windows use fractions 0.8 and 0.4.
// - Standby timing uses a fallback period of nominally 0.9 s.
// - Standby fault pulse is one 320th of fallback period.
// - Safety gate is push-pull, active low.
// - Reset output is open drain: only pulled low.
// - Kick falling edge in service window restarts the period.
// - Kick in shut window asserts reset and restarts the sequence.
// - Kicks are ignored while the power-on delay runs.
// - Gate inactive after any reset until three consecutive good kicks.
module wwsup_core #(
	parameter int unsigned WATCH_CYC = `WWSUP_WATCH_CYC,
	parameter int unsigned POR_CYC   = `WWSUP_POR_CYC,
	parameter int unsigned FB_CYC    = `WWSUP_FB_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic volt_good,
	input  wire logic kick_in_n,
	output var  logic cpu_hold_low_o,
	output var  logic cpu_hold_low_oe,
	output var  logic safety_gate_n,
	output var  logic standby
);
	localparam int unsigned SHUT_CYC =
		WATCH_CYC / 1000 * `WWSUP_SHUT_PERMIL;
	localparam int unsigned SERV_CYC =
		WATCH_CYC / 1000 * `WWSUP_SERV_PERMIL;
	localparam int unsigned PULSE_CYC = WATCH_CYC / `WWSUP_PULSE_DIV;
	localparam int unsigned FB_SHUT_CYC =
		FB_CYC / 1000 * `WWSUP_SHUT_PERMIL;
	localparam int unsigned FB_SERV_CYC =
		FB_CYC / 1000 * `WWSUP_SERV_PERMIL;
	localparam int unsigned FB_PULSE_CYC = FB_CYC / `WWSUP_FB_PULSE_DIV;
	// Local aliases keep the state names short
	localparam wwsup_pkg::wwsup_state_t WW_OFF   = wwsup_pkg::WW_OFF;
	localparam wwsup_pkg::wwsup_state_t WW_POR   = wwsup_pkg::WW_POR;
	localparam wwsup_pkg::wwsup_state_t WW_SHUT  = wwsup_pkg::WW_SHUT;
	localparam wwsup_pkg::wwsup_state_t WW_SERV  = wwsup_pkg::WW_SERV;
	localparam wwsup_pkg::wwsup_state_t WW_FAULT = wwsup_pkg::WW_FAULT;

	wwsup_pkg::wwsup_state_t state_r;
	wwsup_pkg::wwsup_state_t state_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [1:0]  good_r;
	logic [1:0]  good_nxt;
	logic [2:0]  idle_r;
	logic [2:0]  idle_nxt;
	logic        vg_meta_r;
	logic        vg_sync_r;
	logic        kick_d_r;
	logic        hold_r;
	logic        gate_n_r;
	logic        stby_r;
	wwsup_pkg::wwsup_out_t out_nxt;

	wire kick_fall  = kick_d_r & ~kick_in_n;
	wire cnt_last   = (cnt_r == 32'h0000_0001);
	wire [31:0] shut_len  = stby_r ? FB_SHUT_CYC  : SHUT_CYC;
	wire [31:0] serv_len  = stby_r ? FB_SERV_CYC  : SERV_CYC;
	wire [31:0] pulse_len = stby_r ? FB_PULSE_CYC : PULSE_CYC;
	// Saturates once the gate has been earned
	wire good_done  = (good_r == 2'(`WWSUP_GOOD_KICKS));

	always_ff @(posedge clk) begin
		if (rst) begin
			vg_meta_r <= 1'b0;
			vg_sync_r <= 1'b0;
			kick_d_r  <= 1'b1;
		end else if (clk_en) begin
			vg_meta_r <= volt_good;
			vg_sync_r <= vg_meta_r;
			kick_d_r  <= kick_in_n;
		end
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r - 32'h0000_0001;
		good_nxt  = good_r;
		idle_nxt  = idle_r;
		unique case (state_r)
			WW_OFF: begin
				cnt_nxt = POR_CYC;
				if (vg_sync_r) begin
					state_nxt = WW_POR;
				end
			end
			WW_POR: begin
				if (cnt_last) begin
					state_nxt = WW_SHUT;
					cnt_nxt   = SHUT_CYC;
					good_nxt  = 2'h0;
				end
			end
			WW_SHUT: begin
				if (kick_fall) begin
					state_nxt = WW_FAULT;
					cnt_nxt   = pulse_len;
					good_nxt  = 2'h0;
				end else if (cnt_last) begin
					state_nxt = WW_SERV;
					cnt_nxt   = serv_len;
				end
			end
			WW_SERV: begin
				if (kick_fall) begin
					state_nxt = WW_SHUT;
					cnt_nxt   = SHUT_CYC;
					idle_nxt  = 3'h0;
					if (!good_done) begin
						good_nxt = good_r + 2'h1;
					end
				end else if (cnt_last) begin
					state_nxt = WW_FAULT;
					cnt_nxt   = pulse_len;
					good_nxt  = 2'h0;
					if (idle_r != 3'(`WWSUP_IDLE_PERIODS)) begin
						idle_nxt = idle_r + 3'h1;
					end
				end
			end
			WW_FAULT: begin
				if (cnt_last) begin
					state_nxt = WW_SHUT;
					cnt_nxt   = shut_len;
				end
			end
			default: begin
				state_nxt = WW_OFF;
			end
		endcase
		if (!vg_sync_r) begin
			state_nxt = WW_OFF;
			cnt_nxt   = POR_CYC;
			good_nxt  = 2'h0;
			idle_nxt  = 3'h0;
		end
		// hold low outside the running windows
		out_nxt.hold_low = (state_nxt == WW_OFF) || (state_nxt == WW_POR)
			|| (state_nxt == WW_FAULT);
		// gate held off until three good kicks
		out_nxt.gate_n = out_nxt.hold_low
			|| (good_nxt != 2'(`WWSUP_GOOD_KICKS));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r  <= WW_OFF;
			cnt_r    <= 32'h0000_0001;
			good_r   <= 2'h0;
			idle_r   <= 3'h0;
			hold_r   <= 1'b1;
			gate_n_r <= 1'b1;
			stby_r   <= 1'b0;
		end else if (clk_en) begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			good_r   <= good_nxt;
			idle_r   <= idle_nxt;
			hold_r   <= out_nxt.hold_low;
			gate_n_r <= out_nxt.gate_n;
			stby_r   <= (idle_nxt == 3'(`WWSUP_IDLE_PERIODS));
		end
	end

	assign cpu_hold_low_o  = 1'b0;
	assign cpu_hold_low_oe = hold_r;
	assign safety_gate_n   = gate_n_r;
	assign standby         = stby_r;

	property p_low_volt;
		@(posedge clk) disable iff (rst)
		(clk_en && !vg_sync_r) |=> (cpu_hold_low_oe && safety_gate_n);
	endproperty
	a_low_volt: assert property (p_low_volt)
		else $error("reset not held at low voltage");

	property p_early;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && state_r == WW_SHUT && kick_fall)
		|=> (state_r == WW_FAULT && cpu_hold_low_oe);
	endproperty
	a_early: assert property (p_early)
		else $error("early kick did not fault");

	property p_late;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && state_r == WW_SERV && !kick_fall && cnt_last)
		|=> (state_r == WW_FAULT);
	endproperty
	a_late: assert property (p_late)
		else $error("late kick did not fault");

	property p_good;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && state_r == WW_SERV && kick_fall)
		|=> (state_r == WW_SHUT && !cpu_hold_low_oe && cnt_r == SHUT_CYC);
	endproperty
	a_good: assert property (p_good)
		else $error("good kick did not restart period");

	property p_por_ign;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && state_r == WW_POR && !cnt_last)
		|=> (state_r == WW_POR);
	endproperty
	a_por_ign: assert property (p_por_ign)
		else $error("power-on delay cut short");

	property p_gate_hold;
		@(posedge clk) disable iff (rst)
		cpu_hold_low_oe |-> safety_gate_n;
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gate active during reset");

	property p_gate_cnt;
		@(posedge clk) disable iff (rst)
		!safety_gate_n |-> (good_r == 2'(`WWSUP_GOOD_KICKS));
	endproperty
	a_gate_cnt: assert property (p_gate_cnt)
		else $error("gate active before three services");

	sequence s_fault_end;
		clk_en && state_r == WW_FAULT && cnt_last && vg_sync_r;
	endsequence
	property p_fault_end;
		@(posedge clk) disable iff (rst)
		s_fault_end |=> (state_r == WW_SHUT && !cpu_hold_low_oe);
	endproperty
	a_fault_end: assert property (p_fault_end)
		else $error("fault pulse did not end");

	property p_por_end;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && state_r == WW_POR && cnt_last)
		|=> (state_r == WW_SHUT && !cpu_hold_low_oe);
	endproperty
	a_por_end: assert property (p_por_end)
		else $error("hold not released after power-on delay");

	property p_serv_len;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && !stby_r && state_r == WW_SHUT && !kick_fall
		&& cnt_last) |=> (state_r == WW_SERV && cnt_r == SERV_CYC);
	endproperty
	a_serv_len: assert property (p_serv_len)
		else $error("service window length wrong");

	sequence s_miss;
		clk_en && vg_sync_r && state_r == WW_SERV && !kick_fall && cnt_last;
	endsequence
	property p_pulse_len;
		@(posedge clk) disable iff (rst)
		(s_miss ##0 !stby_r) |=> (cnt_r == PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("fault pulse length wrong");

	property p_fb_pulse;
		@(posedge clk) disable iff (rst)
		(s_miss ##0 stby_r) |=> (cnt_r == FB_PULSE_CYC);
	endproperty
	a_fb_pulse: assert property (p_fb_pulse)
		else $error("standby fault pulse length wrong");

	property p_standby;
		@(posedge clk) disable iff (rst)
		(s_miss ##0 idle_r == 3'(`WWSUP_IDLE_PERIODS - 1)) |=> standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not entered after missed windows");

	property p_fb_shut;
		@(posedge clk) disable iff (rst)
		(clk_en && vg_sync_r && stby_r && state_r == WW_FAULT && cnt_last)
		|=> (state_r == WW_SHUT && cnt_r == FB_SHUT_CYC);
	endproperty
	a_fb_shut: assert property (p_fb_shut)
		else $error("standby shut window length wrong");

	property p_freeze;
		@(posedge clk) disable iff (rst)
		!clk_en |=> ($stable(cnt_r) && $stable(state_r)
		&& $stable(cpu_hold_low_oe));
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// File: common/wwsup_cfg.svh
// Timing constants for the windowed watchdog supervisor
`ifndef WWSUP_CFG_SVH
`define WWSUP_CFG_SVH
`define WWSUP_CLK_HZ        50000000
`define WWSUP_WATCH_MS      100
`define WWSUP_SHUT_PERMIL   800
`define WWSUP_SERV_PERMIL   400
`define WWSUP_PULSE_DIV     40
`define WWSUP_FALLBACK_MS   900
`define WWSUP_FB_PULSE_DIV  320
`define WWSUP_POR_MS        100
`define WWSUP_IDLE_PERIODS  4
`define WWSUP_GOOD_KICKS    3
`define WWSUP_WATCH_CYC  ((`WWSUP_CLK_HZ / 1000) * `WWSUP_WATCH_MS)
`define WWSUP_POR_CYC    ((`WWSUP_CLK_HZ / 1000) * `WWSUP_POR_MS)
`define WWSUP_FB_CYC     ((`WWSUP_CLK_HZ / 1000) * `WWSUP_FALLBACK_MS)
`endif

// File: common/wwsup_pkg.sv
// Types for the windowed watchdog supervisor
`default_nettype none
package wwsup_pkg;
	typedef enum logic [2:0] {
		WW_OFF,
		WW_POR,
		WW_SHUT,
		WW_SERV,
		WW_FAULT
	} wwsup_state_t;
	typedef struct packed {
		logic hold_low;
		logic gate_n;
	} wwsup_out_t;
endpackage
`default_nettype wire

// File: testbench/wwsup_host.sv
// Host model: pulses the watchdog kick line on request
`timescale 1ns/1ps
`default_nettype none
module wwsup_host (
	input  wire logic clk,
	input  wire logic kick_req,
	output var  logic kick_in_n
);
	logic [1:0] low_cnt_r;
	initial low_cnt_r = 2'h0;
	always @(negedge clk) begin
		if (kick_req) begin
			low_cnt_r <= 2'h2;
		end else if (low_cnt_r != 2'h0) begin
			low_cnt_r <= low_cnt_r - 2'h1;
		end
	end
	// Idle high, as with a pull-up
	assign kick_in_n = (low_cnt_r == 2'h0);
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the windowed watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int PULSE = 1000 / 40;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic volt_good = 1'b1;
	logic kick_req = 1'b0;
	logic clk_en = 1'b1;
	wire logic kick_in_n, hold_o, hold_oe, safety_gate_n, standby, hold_line;
	int err_count = 0;
	int total_checks = 0;
	int n;
	// Open drain with pull-up
	assign hold_line = hold_oe ? hold_o : 1'b1;
	wwsup_host host (.clk(clk), .kick_req(kick_req), .kick_in_n(kick_in_n));
	wwsup_core #(.WATCH_CYC(1000), .POR_CYC(1000), .FB_CYC(9000)) uut (
		.clk(clk), .rst(rst), .clk_en(clk_en), .volt_good(volt_good),
		.kick_in_n(kick_in_n), .cpu_hold_low_o(hold_o),
		.cpu_hold_low_oe(hold_oe), .safety_gate_n(safety_gate_n),
		.standby(standby));
	initial forever #10 clk = ~clk;
	task automatic finish_test();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic in_range(input int v, input int lo, input int hi);
		cmp({31'h0, v >= lo && v <= hi}, 32'h1);
	endtask
	task automatic wait_line(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (hold_line !== lvl) begin
			@(negedge clk);
			cnt++;
			if (cnt > lim) begin
				cmp(32'h1, 32'h0);
				finish_test();
			end
		end
	endtask
	task automatic kick();
		kick_req <= 1'b1;
		@(negedge clk);
		kick_req <= 1'b0;
	endtask
	task automatic s_por();
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (500) @(negedge clk);
		kick();
		wait_line(1'b1, 700, n);
		in_range(n + 501, 1000, 1008);
		cmp(safety_gate_n, 1'b1);
	endtask
	task automatic s_good();
		for (int i = 0; i < 3; i++) begin
			cmp(safety_gate_n, 1'b1);
			repeat (900) @(negedge clk);
			kick();
			// Let the kick reach the registered output
			repeat (2) @(negedge clk);
			cmp(hold_line, 1'b1);
		end
		repeat (4) @(negedge clk);
		cmp(safety_gate_n, 1'b0);
	endtask
	task automatic s_early();
		repeat (100) @(negedge clk);
		kick();
		wait_line(1'b0, 6, n);
		in_range(n, 1, 2);
		cmp(hold_o, 1'b0);
		repeat (2) @(negedge clk);
		cmp(safety_gate_n, 1'b1);
		wait_line(1'b1, 40, n);
		in_range(n, PULSE - 4, PULSE + 2);
	endtask
	task automatic s_late();
		wait_line(1'b0, 1210, n);
		// Shut plus service is 1200 cycles
		in_range(n, 1194, 1204);
		wait_line(1'b1, 40, n);
		in_range(n, PULSE - 2, PULSE + 2);
	endtask
	task automatic s_standby();
		n = 0;
		while (standby !== 1'b1 && n < 6000) begin
			@(negedge clk);
			n++;
		end
		cmp(standby, 1'b1);
		// Last normal pulse is still running here
		wait_line(1'b1, 40, n);
		wait_line(1'b0, 12000, n);
		// Fallback shut plus service is 10800 cycles
		in_range(n, 10795, 10805);
		wait_line(1'b1, 60, n);
		// Fallback pulse is 9000 / 320 cycles
		in_range(n, 26, 30);
		repeat (8000) @(negedge clk);
		kick();
		repeat (4) @(negedge clk);
		cmp(standby, 1'b0);
		cmp(hold_line, 1'b1);
	endtask
	task automatic s_freeze();
		int lows;
		lows = 0;
		// Frozen long enough that a running block would fault
		clk_en = 1'b0;
		repeat (1300) begin
			@(negedge clk);
			if (hold_line !== 1'b1) begin
				lows++;
			end
		end
		clk_en = 1'b1;
		cmp(lows, 0);
	endtask
	task automatic s_volt();
		repeat (300) @(negedge clk);
		volt_good = 1'b0;
		repeat (5) @(negedge clk);
		cmp(hold_line, 1'b0);
		cmp(safety_gate_n, 1'b1);
		volt_good = 1'b1;
		wait_line(1'b1, 1100, n);
		in_range(n, 1000, 1010);
	endtask
	initial begin
		s_por();
		s_good();
		s_early();
		s_late();
		s_standby();
		s_freeze();
		s_volt();
		finish_test();
	end
endmodule
`default_nettype wire
